//--- hdl/pin_mux_consts.svh
// constants for the shared pin function mux
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH
`define PIN_COUNT 5
`define PIN_SYNC 0
`define PIN_DEBUG_SERIAL_LINE 0
`define PIN_DEBUG_SERIAL_CLOCK 1
`define PIN_DBG_SEL 2
`define DIR_RESET 5'h00
`define PULL_RESET 5'h00
`define LEVEL_RESET 5'h00
`endif

//--- hdl/pin_mux_pkg.sv
// types for the shared pin function mux
package pin_mux_pkg;
    typedef enum logic [1:0] {
        sync_off = 2'h0,
        sync_frame = 2'h1,
        sync_pulse = 2'h3
    } sync_role_t;
    typedef struct packed {
        logic [4:0] dir_out;
        logic [4:0] pull_en;
        logic [4:0] level;
    } gpio_cfg_t;
    typedef struct packed {
        logic [4:0] data;
        logic [4:0] oe;
        logic [4:0] pull;
    } pin_drive_t;
endpackage : pin_mux_pkg

//--- hdl/pin_cfg_regs.sv
// held pin configuration store
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.svh"
module pin_cfg_regs
    import pin_mux_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic wr_i,
    input wire gpio_cfg_t wdata_i,
    output var gpio_cfg_t cfg_o
);
    // configuration held until rewritten
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_o <= {`DIR_RESET, `PULL_RESET, `LEVEL_RESET};
        end else if (ce_i && wr_i) begin
            cfg_o <= wdata_i;
        end
    end
endmodule : pin_cfg_regs
`default_nettype wire

//--- hdl/shared_pin_function_mux.sv
// pin function arbitration for five shared general pins
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.svh"
module shared_pin_function_mux
    import pin_mux_pkg::*;
#(
    parameter int PINS = `PIN_COUNT
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic cfg_enable_i,
    input wire logic cfg_wr_i,
    input wire logic [PINS-1:0] cfg_dir_out_i,
    input wire logic [PINS-1:0] cfg_pull_en_i,
    input wire logic [PINS-1:0] cfg_level_i,
    input wire logic sync_en_i,
    input wire logic sync_pulse_mode_i,
    input wire logic debug_port_en_i,
    input wire logic debug_select_en_i,
    input wire logic debug_data_out_i,
    input wire logic debug_data_oe_i,
    input wire logic [PINS-1:0] pad_in_i,
    output logic [PINS-1:0] pad_out_o,
    output logic [PINS-1:0] pad_oe_o,
    output logic [PINS-1:0] pad_pull_o,
    output logic [PINS-1:0] gpio_in_o,
    output logic frame_sync_o,
    output logic pulse_sync_o,
    output logic debug_serial_clock_o,
    output logic debug_serial_line_o,
    output logic debug_port_select_o,
    output var sync_role_t sync_role_o
);
    // ***********************************************
    // configuration store
    // ***********************************************
    gpio_cfg_t cfg;
    gpio_cfg_t cfg_wdata;
    assign cfg_wdata = {cfg_dir_out_i, cfg_pull_en_i, cfg_level_i};
    pin_cfg_regs pin_cfg_regs_inst (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .wr_i(cfg_wr_i),
        .wdata_i(cfg_wdata),
        .cfg_o(cfg)
    );

    // ***********************************************
    // ownership decode
    // ***********************************************
    wire sync_owns = sync_en_i;
    wire dbg_owns = debug_port_en_i;
    wire sel_owns = debug_select_en_i;
    // one role only, pulse chosen by mode bit
    sync_role_t next_sync_role;
    assign next_sync_role = !sync_en_i ? sync_off :
        (sync_pulse_mode_i ? sync_pulse : sync_frame);
    // debug data has priority on pin zero over sync
    wire [PINS-1:0] alt_own;
    assign alt_own = {{(PINS-3){1'b0}}, sel_owns, dbg_owns,
        (dbg_owns | sync_owns)};

    wire pin_drive_t next_drv;
    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            wire gpio_live = cfg_enable_i && !alt_own[i];
            wire alt_oe = (i == `PIN_DEBUG_SERIAL_LINE) && dbg_owns
                && debug_data_oe_i;
            assign next_drv.oe[i] = gpio_live ? cfg.dir_out[i]
                : alt_oe;
            assign next_drv.data[i] = gpio_live ? cfg.level[i]
                : (alt_oe && debug_data_out_i);
            assign next_drv.pull[i] = gpio_live && cfg.pull_en[i]
                && !cfg.dir_out[i];
        end
    endgenerate

    wire [PINS-1:0] gpio_live_in = {PINS{cfg_enable_i}} & ~alt_own
        & ~cfg.dir_out;

    // ***********************************************
    // output registers
    // ***********************************************
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pad_out_o <= '0;
            pad_oe_o <= '0;
            pad_pull_o <= '0;
            gpio_in_o <= '0;
        end else if (ce_i) begin
            pad_out_o <= next_drv.data;
            pad_oe_o <= next_drv.oe;
            pad_pull_o <= next_drv.pull;
            gpio_in_o <= pad_in_i & gpio_live_in;
        end
    end

    // ***********************************************
    // alternative function registers
    // ***********************************************
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            frame_sync_o <= 1'h0;
            pulse_sync_o <= 1'h0;
            debug_serial_clock_o <= 1'h0;
            debug_serial_line_o <= 1'h0;
            debug_port_select_o <= 1'h0;
            sync_role_o <= sync_off;
        end else if (ce_i) begin
            sync_role_o <= next_sync_role;
            frame_sync_o <= sync_owns && !dbg_owns
                && !sync_pulse_mode_i && pad_in_i[`PIN_SYNC];
            pulse_sync_o <= sync_owns && !dbg_owns
                && sync_pulse_mode_i && pad_in_i[`PIN_SYNC];
            debug_serial_clock_o <= dbg_owns
                && pad_in_i[`PIN_DEBUG_SERIAL_CLOCK];
            debug_serial_line_o <= dbg_owns
                && pad_in_i[`PIN_DEBUG_SERIAL_LINE];
            debug_port_select_o <= sel_owns
                && pad_in_i[`PIN_DBG_SEL];
        end
    end

    // ***********************************************
    // ownership checks
    // ***********************************************
    chk_sync_one_role: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) !(frame_sync_o && pulse_sync_o))
        else $error("both sync roles active");
    chk_frame_role: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) frame_sync_o
        |-> sync_role_o == sync_frame)
        else $error("frame sync without frame role");
    chk_pulse_role: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) pulse_sync_o
        |-> sync_role_o == sync_pulse)
        else $error("pulse sync without pulse role");
    chk_dbg_over_sync: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) (ce_i && debug_port_en_i)
        |=> !frame_sync_o && !pulse_sync_o)
        else $error("sync output active under debug");
    chk_sync_pin_zero: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) (ce_i && sync_en_i && !debug_port_en_i)
        |=> !pad_oe_o[0] && !gpio_in_o[0])
        else $error("pin zero used as gpio under sync");
    chk_dbg_pin_one: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) (ce_i && debug_port_en_i) |=>
        !pad_oe_o[1] && !gpio_in_o[1])
        else $error("pin one used as gpio under debug");
    chk_dbg_pin_zero: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) (ce_i && debug_port_en_i) |=>
        pad_oe_o[0] == $past(debug_data_oe_i))
        else $error("pin zero not owned by debug");
    chk_sel_pin_two: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) (ce_i && debug_select_en_i) |=>
        !pad_oe_o[2] && !gpio_in_o[2])
        else $error("pin two used as gpio under select");
    chk_dbg_return: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) (ce_i && $fell(debug_port_en_i)
        && cfg_enable_i && !cfg.dir_out[1])
        |=> gpio_in_o[1] == $past(pad_in_i[1]))
        else $error("pin one not returned to gpio");

    // ***********************************************
    // gpio checks
    // ***********************************************
    chk_gpio_reset_in: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) $rose(reset_n_i) |-> pad_oe_o == '0)
        else $error("pin driven after reset");
    chk_disabled_no_gpio: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) (ce_i && !cfg_enable_i) |=>
        gpio_in_o == '0 && pad_pull_o == '0)
        else $error("gpio active while disabled");
    chk_out_level: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) (ce_i && cfg_enable_i
        && !debug_select_en_i && cfg.dir_out[2]) |=>
        pad_oe_o[2] && pad_out_o[2] == $past(cfg.level[2]))
        else $error("output level not driven");
    chk_pull_follow: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) (ce_i && cfg_enable_i
        && cfg.pull_en[4] && !cfg.dir_out[4]) |=> pad_pull_o[4])
        else $error("pull-up not applied");
    chk_dir_pin_four: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) (ce_i && cfg_enable_i)
        |=> pad_oe_o[4] == $past(cfg.dir_out[4]))
        else $error("pin four direction not followed");
    chk_ce_hold: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i) !ce_i
        |=> $stable(cfg) && $stable(pad_oe_o) && $stable(pad_out_o))
        else $error("state moved while clock enable low");

    // ***********************************************
    // cover points
    // ***********************************************
    cov_frame: cover property (@(posedge mclk_i)
        frame_sync_o);
    cov_pulse: cover property (@(posedge mclk_i)
        pulse_sync_o);
    cov_dbg: cover property (@(posedge mclk_i)
        debug_serial_clock_o);
    cov_sel: cover property (@(posedge mclk_i)
        debug_port_select_o);
    cov_return: cover property (@(posedge mclk_i)
        $fell(debug_port_en_i) ##1 gpio_in_o[1]);
endmodule : shared_pin_function_mux
`default_nettype wire

//--- verif/pad_far_model.sv
// far side model: display timing source and debug hardware
`timescale 1ns/1ps
`default_nettype none
module pad_far_model (
    input wire logic [4:0] pad_out_i,
    input wire logic [4:0] pad_oe_i,
    input wire logic [4:0] ext_i,
    output logic [4:0] pad_in_o
);
    // driven pads read back, released pads follow the far side
    assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule : pad_far_model
`default_nettype wire

//--- verif/shared_pin_function_mux_tb.sv
// self-checking bench for the shared pin function mux
`timescale 1ns/1ps
`default_nettype none
module shared_pin_function_mux_tb;
    import pin_mux_pkg::*;
    logic mclk_i = 1'b0, reset_n_i = 1'b0, ce = 1'b1, en = 1'b0, wr = 1'b0;
    logic sen = 1'b0, pmode = 1'b0, dport = 1'b0, dsel = 1'b0;
    logic dout = 1'b0, doe = 1'b0;
    logic [4:0] dir = 5'h00, pull = 5'h00, lvl = 5'h00, ext = 5'h00;
    logic [4:0] pin, pout, poe, ppull, gin;
    logic fs, ps, dclk, dline, dss;
    sync_role_t role;
    int err_count = 0, total_checks = 0;
    shared_pin_function_mux #(.PINS(5)) shared_pin_function_mux_inst (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce),
        .cfg_enable_i(en), .cfg_wr_i(wr), .cfg_dir_out_i(dir),
        .cfg_pull_en_i(pull), .cfg_level_i(lvl), .sync_en_i(sen),
        .sync_pulse_mode_i(pmode), .debug_port_en_i(dport),
        .debug_select_en_i(dsel), .debug_data_out_i(dout),
        .debug_data_oe_i(doe), .pad_in_i(pin), .pad_out_o(pout),
        .pad_oe_o(poe), .pad_pull_o(ppull), .gpio_in_o(gin),
        .frame_sync_o(fs), .pulse_sync_o(ps), .debug_serial_clock_o(dclk),
        .debug_serial_line_o(dline), .debug_port_select_o(dss),
        .sync_role_o(role));
    pad_far_model pad_far_model_inst (.pad_out_i(pout), .pad_oe_i(poe),
        .ext_i(ext), .pad_in_o(pin));
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up;
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    task automatic t_gpio;
        chk(poe, 5'h00);
        en = 1'b1;
        dir = 5'h1C;
        lvl = 5'h04;
        pull = 5'h03;
        ext = 5'h02;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(2);
        chk(poe, 5'h1C);
        chk(pout, 5'h04);
        chk(ppull, 5'h03);
        chk(gin, 5'h02);
    endtask : t_gpio
    task automatic t_debug;
        dport = 1'b1;
        doe = 1'b1;
        dout = 1'b1;
        tick(2);
        chk(poe, 5'h1D);
        chk(pout, 5'h05);
        chk(gin, 5'h00);
        chk({3'h0, dclk, dline}, 5'h03);
        dsel = 1'b1;
        ext = 5'h06;
        tick(2);
        chk(poe, 5'h19);
        chk({4'h0, dss}, 5'h01);
        dport = 1'b0;
        dsel = 1'b0;
        doe = 1'b0;
        tick(2);
        chk(poe, 5'h1C);
        chk(ppull, 5'h03);
    endtask : t_debug
    task automatic t_sync;
        sen = 1'b1;
        ext = 5'h03;
        tick(2);
        chk({3'h0, role}, 5'h01);
        chk({3'h0, fs, ps}, 5'h02);
        chk(gin, 5'h02);
        pmode = 1'b1;
        tick(2);
        chk({3'h0, role}, 5'h03);
        chk({3'h0, fs, ps}, 5'h01);
        sen = 1'b0;
        tick(2);
        chk(gin, 5'h03);
    endtask : t_sync
    task automatic t_cfg_off;
        en = 1'b0;
        dport = 1'b1;
        ext = 5'h02;
        tick(2);
        chk(poe, 5'h00);
        chk(gin, 5'h00);
        chk({4'h0, dclk}, 5'h01);
    endtask : t_cfg_off
    task automatic t_hold;
        ce = 1'b0;
        en = 1'b1;
        dport = 1'b0;
        ext = 5'h00;
        dir = 5'h00;
        lvl = 5'h1F;
        wr = 1'b1;
        tick(2);
        chk(poe, 5'h00);
        chk(pout, 5'h00);
        chk({4'h0, dclk}, 5'h01);
        ce = 1'b1;
        wr = 1'b0;
        ext = 5'h02;
        tick(2);
        chk(poe, 5'h1C);
        chk(pout, 5'h04);
        chk(gin, 5'h02);
    endtask : t_hold
    task automatic t_mid_reset;
        sen = 1'b1;
        pmode = 1'b0;
        dport = 1'b1;
        ext = 5'h01;
        tick(2);
        chk({2'h0, fs, ps, dline}, 5'h01);
        chk(poe, 5'h1C);
        reset_n_i = 1'b0;
        tick(2);
        chk(poe, 5'h00);
        reset_n_i = 1'b1;
        tick(1);
        chk(poe, 5'h00);
        chk(pout, 5'h00);
        sen = 1'b0;
        dport = 1'b0;
        tick(2);
        chk(poe, 5'h00);
        chk(ppull, 5'h00);
        chk(gin, 5'h01);
    endtask : t_mid_reset
    initial begin
        #100000;
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        #1 reset_n_i = 1'b1;
        tick(1);
        t_gpio();
        t_debug();
        t_sync();
        t_cfg_off();
        t_hold();
        t_mid_reset();
        wrap_up();
    end
endmodule : shared_pin_function_mux_tb
`default_nettype wire
